/* File: hw/dos_pkg.sv */
// Constants and types of the DAC output sequencer
package dos_pkg;
  // Timing
  localparam int DOS_CLK_HZ = 100_000_000;
  localparam int DOS_MAX_SPS = 300_000;
  localparam int DOS_MIN_SPS = 400;
  // Lowest cascaded rate in milli-samples per second (0.006 SPS)
  localparam int DOS_CASC_MIN_MSPS = 6;
  // Shortest update period rounds up, longest ones round down
  localparam int DOS_MIN_DIV = (DOS_CLK_HZ + DOS_MAX_SPS - 1) / DOS_MAX_SPS;
  localparam int DOS_MAX_DIV_A = DOS_CLK_HZ / DOS_MIN_SPS;
  localparam longint DOS_MAX_DIV_TOT =
    64'(DOS_CLK_HZ) * 64'd1000 / 64'(DOS_CASC_MIN_MSPS);
  localparam int DOS_MAX_DIV_B = int'(DOS_MAX_DIV_TOT / 64'(DOS_MAX_DIV_A));
  // Sizes
  localparam int DOS_FIFO_DEPTH = 32768;
  localparam int DOS_NUM_CH = 8;
  localparam int DOS_DATA_W = 16;
  localparam int DOS_CH_W = 3;
  localparam int DOS_AUX_W = 4;
  localparam int DOS_RATE_W = 18;
  localparam int DOS_LEN_W = 16;
  // FIFO word layout
  localparam int DOS_W_CH_LSB = 16;
  localparam int DOS_W_GRP_END = 19;
  localparam int DOS_W_BURST_END = 20;
  localparam int DOS_WORD_W = 21;
  // Register byte offsets
  localparam logic [5:0] DOS_REG_CTRL = 6'h00;
  localparam logic [5:0] DOS_REG_RATE_A = 6'h04;
  localparam logic [5:0] DOS_REG_RATE_B = 6'h08;
  localparam logic [5:0] DOS_REG_THRESH = 6'h0c;
  localparam logic [5:0] DOS_REG_FIFO = 6'h10;
  localparam logic [5:0] DOS_REG_STATUS = 6'h14;
  localparam logic [5:0] DOS_REG_CMD = 6'h18;
  localparam logic [5:0] DOS_REG_AUX = 6'h1c;
  localparam logic [5:0] DOS_REG_DMA_ADDR = 6'h20;
  localparam logic [5:0] DOS_REG_DMA_LEN = 6'h24;
  // Control fields
  localparam int DOS_CTRL_MODE_LSB = 0;
  localparam int DOS_CTRL_SRC_LSB = 2;
  localparam int DOS_CTRL_CASC = 4;
  localparam int DOS_CTRL_RUN = 5;
  localparam int DOS_CTRL_IRQ_EN = 6;
  localparam int DOS_CTRL_W = 7;
  // Command bits
  localparam int DOS_CMD_SW_CLK = 0;
  localparam int DOS_CMD_SW_SYNC = 1;
  localparam int DOS_CMD_FIFO_CLR = 2;
  localparam int DOS_CMD_DMA_GO = 3;
  // Status bits above the fill count
  localparam int DOS_ST_THR = 16;
  localparam int DOS_ST_EMPTY = 17;
  localparam int DOS_ST_FULL = 18;
  localparam int DOS_ST_BURST = 19;
  localparam int DOS_ST_DMA = 20;
  localparam int DOS_ST_GRP = 21;
  // Reset values
  localparam logic [DOS_CTRL_W-1:0] DOS_CTRL_RST = 7'h00;
  localparam logic [DOS_RATE_W-1:0] DOS_RATE_RST = 18'h00000;
  localparam logic [DOS_AUX_W-1:0] DOS_AUX_RST = 4'h0;
  localparam logic [3:0] DOS_BE_FULL = 4'hf;

  typedef enum logic [1:0] {
    DOS_SIM_CONT, DOS_SIM_BURST, DOS_SEQ_CONT, DOS_SEQ_BURST
  } dos_mode_t;
  typedef enum logic [1:0] {
    DOS_SRC_RATE, DOS_SRC_SW, DOS_SRC_EXT, DOS_SRC_NONE
  } dos_src_t;
  typedef enum logic {DOS_BS_IDLE, DOS_BS_RUN} dos_burst_t;
endpackage

/* File: hw/dos_sequencer.sv */
// DAC output sequencer: sample FIFO, clocking modes, DMA feed, registers
// Summary of operation
// - Simultaneous continuous: stage a group, move it to DACs on clock.
// - Output clock from rate generator, software flag or external trigger.
// - Simultaneous burst starts only on a software or hardware sync.
// - During a burst, staged groups go out on each rate generator pulse.
// - A word with burst-end set ends the running burst.
// - Sequential modes write each value straight to its DAC.
// - Group-end marker is ignored in sequential modes.
// - Three-bit channel field picks the DAC that takes the data.
// - One word bit marks the last value of a channel group.
// - One word bit marks the last value of a burst.
// - 32K-sample FIFO with threshold programmable 0000h to 7FFFh.
// - Sixteen-bit data field, one DAC code per channel.
// - Rate 400 SPS to 300 KSPS; cascaded generators reach 0.006 SPS.
// - Sync-paced updates accepted at any rate up to 300 KSPS.
// - Only full 32-bit reads and writes are carried.
// - Device fetches FIFO data by DMA as bus master.
// - All events share one interrupt request line.
// - Four software-driven auxiliary output lines.
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module dos_sequencer
  import dos_pkg::*;
#(
  parameter int DEPTH = DOS_FIFO_DEPTH,
  parameter int MAX_DIV_A = DOS_MAX_DIV_A,
  parameter int MAX_DIV_B = DOS_MAX_DIV_B
) (
  input wire logic core_clk_i, // 100 MHz core clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [5:0] avs_address_i, // Slave byte address
  input wire logic avs_read_i, // Slave read request
  input wire logic avs_write_i, // Slave write request
  input wire logic [31:0] avs_writedata_i, // Slave write data
  input wire logic [3:0] avs_byteenable_i, // Slave byte enables
  output logic [31:0] avs_readdata_o, // Slave read data
  output logic avs_waitrequest_o, // Slave wait request
  output logic [31:0] avm_address_o, // DMA master byte address
  output logic avm_read_o, // DMA master read request
  input wire logic avm_waitrequest_i, // DMA master wait request
  input wire logic [31:0] avm_readdata_i, // DMA master read data
  input wire logic external_sync_input_i, // Trigger pin, asynchronous
  output logic [DOS_NUM_CH-1:0][DOS_DATA_W-1:0] dac_code_o, // DAC codes
  output logic [DOS_NUM_CH-1:0] dac_load_o, // Per-DAC load pulse
  output logic [DOS_AUX_W-1:0] aux_control_line_o, // Auxiliary lines
  output logic irq_o // Shared interrupt request
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [DOS_RATE_W-1:0] clamp_div(
    input logic [DOS_RATE_W-1:0] v, input int lo, input int hi);
    logic [DOS_RATE_W-1:0] r;
    r = v;
    if (int'(v) < lo) r = DOS_RATE_W'(lo);
    if (int'(v) > hi) r = DOS_RATE_W'(hi);
    return r;
  endfunction

  function automatic logic [DOS_NUM_CH-1:0] one_hot(
    input logic [DOS_CH_W-1:0] ch);
    logic [DOS_NUM_CH-1:0] r;
    r = '0;
    r[ch] = 1'b1;
    return r;
  endfunction

  // Register file state
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [DOS_CTRL_W-1:0] ctrl_reg;
  logic [DOS_RATE_W-1:0] rate_a_reg, rate_b_reg;
  logic [AW-1:0] thr_reg;
  logic [DOS_AUX_W-1:0] aux_reg;
  logic [31:0] dma_addr_reg;
  logic [DOS_LEN_W-1:0] dma_len_reg;
  logic dma_busy_reg, dma_rd_reg;
  logic irq_reg;
  // FIFO state
  logic [DOS_WORD_W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [AW:0] cnt_reg;
  logic thr_flag_reg;
  // Trigger synchroniser
  logic ext_s1_reg, ext_s2_reg, ext_s3_reg, ext_lvl_reg, ext_edge_reg;
  // Rate generators
  logic [DOS_RATE_W-1:0] cnt_a_reg, cnt_b_reg;
  logic rate_pulse_reg;
  // Sequencer
  dos_burst_t burst_reg;
  logic [DOS_NUM_CH-1:0][DOS_DATA_W-1:0] stage_reg, dac_reg;
  logic [DOS_NUM_CH-1:0] stage_mask_reg, load_reg;
  logic grp_ready_reg, end_pend_reg;

  // Bus decode
  logic bus_take, bus_wr, bus_full_be;
  assign bus_full_be = (avs_byteenable_i == DOS_BE_FULL);
  assign bus_take = (avs_read_i | avs_write_i) & ~wait_reg;
  assign bus_wr = avs_write_i & ~wait_reg & bus_full_be;

  logic wr_cmd;
  assign wr_cmd = bus_wr && (avs_address_i == DOS_REG_CMD);
  logic sw_clk, sw_sync, fifo_clr, dma_go;
  assign sw_clk = wr_cmd & avs_writedata_i[DOS_CMD_SW_CLK];
  assign sw_sync = wr_cmd & avs_writedata_i[DOS_CMD_SW_SYNC];
  assign fifo_clr = wr_cmd & avs_writedata_i[DOS_CMD_FIFO_CLR];
  assign dma_go = wr_cmd & avs_writedata_i[DOS_CMD_DMA_GO];

  dos_mode_t mode;
  dos_src_t src;
  logic run_en, casc;
  assign mode = dos_mode_t'(ctrl_reg[DOS_CTRL_MODE_LSB +: 2]);
  assign src = dos_src_t'(ctrl_reg[DOS_CTRL_SRC_LSB +: 2]);
  assign run_en = ctrl_reg[DOS_CTRL_RUN];
  assign casc = ctrl_reg[DOS_CTRL_CASC];

  // Answer one cycle after a request appears, then rearm
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wait_reg <= 1'b1;
    end else if ((avs_read_i | avs_write_i) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  logic fifo_empty, fifo_full;
  assign fifo_empty = (cnt_reg == '0);
  assign fifo_full = (cnt_reg == (AW+1)'(DEPTH));

  // Read data is prepared while waitrequest is still high
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else if (avs_read_i && wait_reg) begin
      rdata_reg <= '0;
      if (bus_full_be) begin
        case (avs_address_i)
          DOS_REG_CTRL: rdata_reg <= 32'(ctrl_reg);
          DOS_REG_RATE_A: rdata_reg <= 32'(rate_a_reg);
          DOS_REG_RATE_B: rdata_reg <= 32'(rate_b_reg);
          DOS_REG_THRESH: rdata_reg <= 32'(thr_reg);
          DOS_REG_AUX: rdata_reg <= 32'(aux_reg);
          DOS_REG_DMA_ADDR: rdata_reg <= dma_addr_reg;
          DOS_REG_DMA_LEN: rdata_reg <= 32'(dma_len_reg);
          DOS_REG_STATUS: begin
            rdata_reg[AW:0] <= cnt_reg;
            rdata_reg[DOS_ST_THR] <= thr_flag_reg;
            rdata_reg[DOS_ST_EMPTY] <= fifo_empty;
            rdata_reg[DOS_ST_FULL] <= fifo_full;
            rdata_reg[DOS_ST_BURST] <= (burst_reg == DOS_BS_RUN);
            rdata_reg[DOS_ST_DMA] <= dma_busy_reg;
            rdata_reg[DOS_ST_GRP] <= grp_ready_reg;
          end
          default: rdata_reg <= '0;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_reg <= DOS_CTRL_RST;
      rate_a_reg <= DOS_RATE_RST;
      rate_b_reg <= DOS_RATE_RST;
      aux_reg <= DOS_AUX_RST;
    end else if (bus_wr) begin
      case (avs_address_i)
        DOS_REG_CTRL: ctrl_reg <= avs_writedata_i[DOS_CTRL_W-1:0];
        DOS_REG_RATE_A: rate_a_reg <= avs_writedata_i[DOS_RATE_W-1:0];
        DOS_REG_RATE_B: rate_b_reg <= avs_writedata_i[DOS_RATE_W-1:0];
        DOS_REG_AUX:
          aux_reg <= avs_writedata_i[DOS_AUX_W-1:0];
        default: ;
      endcase
    end
  end

  // Threshold register and flag, flag follows the next fill and threshold
  logic [AW-1:0] thr_next;
  logic [AW:0] cnt_next;
  always_comb begin
    thr_next = thr_reg;
    if (bus_wr && avs_address_i == DOS_REG_THRESH) begin
      thr_next = avs_writedata_i[AW-1:0];
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      thr_reg <= '0;
      thr_flag_reg <= 1'b1;
    end else begin
      thr_reg <= thr_next;
      thr_flag_reg <= (cnt_next <= {1'b0, thr_next});
    end
  end

  // DMA read master: one read outstanding, only while the FIFO has room
  logic dma_push;
  assign dma_push = dma_rd_reg & ~avm_waitrequest_i;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dma_addr_reg <= '0;
      dma_len_reg <= '0;
      dma_busy_reg <= 1'b0;
      dma_rd_reg <= 1'b0;
    end else begin
      if (bus_wr && avs_address_i == DOS_REG_DMA_ADDR && !dma_busy_reg) begin
        dma_addr_reg <= avs_writedata_i;
      end
      if (bus_wr && avs_address_i == DOS_REG_DMA_LEN && !dma_busy_reg) begin
        dma_len_reg <= avs_writedata_i[DOS_LEN_W-1:0];
      end
      if (dma_go && dma_len_reg != '0) begin
        dma_busy_reg <= 1'b1;
      end
      if (dma_push) begin
        dma_rd_reg <= 1'b0;
        dma_addr_reg <= dma_addr_reg + 32'd4;
        dma_len_reg <= dma_len_reg - 1'b1;
        if (dma_len_reg == DOS_LEN_W'(1)) dma_busy_reg <= 1'b0;
      end else if (dma_busy_reg && !dma_rd_reg && !fifo_full) begin
        dma_rd_reg <= 1'b1;
      end
    end
  end

  // FIFO; host writes to the data port are ignored while DMA runs
  logic bus_push, push, pop;
  assign bus_push = bus_wr && avs_address_i == DOS_REG_FIFO &&
                    !dma_busy_reg && !fifo_full;
  assign push = bus_push | dma_push;
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= dma_push ? avm_readdata_i[DOS_WORD_W-1:0]
                                  : avs_writedata_i[DOS_WORD_W-1:0];
    end
  end
  always_comb begin
    cnt_next = cnt_reg;
    if (fifo_clr) cnt_next = '0;
    else if (push && !pop) cnt_next = cnt_reg + 1'b1;
    else if (pop && !push) cnt_next = cnt_reg - 1'b1;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      if (fifo_clr) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
      end else begin
        if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
        if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  // Head word fields
  logic [DOS_WORD_W-1:0] head;
  logic [DOS_CH_W-1:0] head_ch;
  logic [DOS_DATA_W-1:0] head_data;
  logic head_grp_end, head_burst_end;
  assign head = mem[rd_ptr_reg];
  assign head_ch = head[DOS_W_CH_LSB +: DOS_CH_W];
  assign head_data = head[DOS_DATA_W-1:0];
  assign head_grp_end = head[DOS_W_GRP_END];
  assign head_burst_end = head[DOS_W_BURST_END];

  // Trigger pin: three stages, level moves when stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
      ext_lvl_reg <= 1'b0;
      ext_edge_reg <= 1'b0;
    end else begin
      ext_s1_reg <= external_sync_input_i;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      if (ext_s2_reg == ext_s3_reg) ext_lvl_reg <= ext_s3_reg;
      ext_edge_reg <= (ext_s2_reg == ext_s3_reg) && ext_s3_reg && !ext_lvl_reg;
    end
  end

  // Rate generators, optionally cascaded
  logic [DOS_RATE_W-1:0] div_a, div_b;
  logic wrap_a, wrap_b;
  assign div_a = clamp_div(rate_a_reg, DOS_MIN_DIV, MAX_DIV_A);
  assign div_b = clamp_div(rate_b_reg, 1, MAX_DIV_B);
  assign wrap_a = (cnt_a_reg >= div_a - 1'b1);
  assign wrap_b = (cnt_b_reg >= div_b - 1'b1);
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !run_en) begin
      cnt_a_reg <= '0;
      cnt_b_reg <= '0;
      rate_pulse_reg <= 1'b0;
    end else begin
      cnt_a_reg <= wrap_a ? '0 : cnt_a_reg + 1'b1;
      if (wrap_a) cnt_b_reg <= wrap_b ? '0 : cnt_b_reg + 1'b1;
      rate_pulse_reg <= wrap_a && (!casc || wrap_b);
    end
  end

  // Clock and sync selection
  logic burst_mode, seq_mode, src_tick, sync_evt, tick;
  assign burst_mode = (mode == DOS_SIM_BURST) || (mode == DOS_SEQ_BURST);
  assign seq_mode = (mode == DOS_SEQ_CONT) || (mode == DOS_SEQ_BURST);
  always_comb begin
    case (src)
      DOS_SRC_RATE: src_tick = rate_pulse_reg;
      DOS_SRC_SW: src_tick = sw_clk;
      DOS_SRC_EXT: src_tick = ext_edge_reg;
      default: src_tick = 1'b0;
    endcase
  end
  assign sync_evt = sw_sync | ext_edge_reg;
  assign tick = run_en && (burst_mode ? (burst_reg == DOS_BS_RUN) &&
                rate_pulse_reg : src_tick);

  logic xfer, asm_pop, seq_pop, burst_stop;
  assign xfer = !seq_mode && grp_ready_reg && tick;
  assign asm_pop = run_en && !seq_mode && !grp_ready_reg && !fifo_empty &&
                   !fifo_clr;
  assign seq_pop = seq_mode && tick && !fifo_empty && !fifo_clr;
  assign pop = asm_pop | seq_pop;
  assign burst_stop = (xfer && end_pend_reg) ||
                      (seq_pop && head_burst_end);

  // Burst state
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      burst_reg <= DOS_BS_IDLE;
    end else begin
      case (burst_reg)
        DOS_BS_IDLE:
          if (run_en && burst_mode && sync_evt) burst_reg <= DOS_BS_RUN;
        DOS_BS_RUN:
          if (!run_en || !burst_mode || burst_stop) burst_reg <= DOS_BS_IDLE;
        default: burst_reg <= DOS_BS_IDLE;
      endcase
    end
  end

  // Group assembly in the staging buffer
  always_ff @(posedge core_clk_i) begin
    if (rst_i || fifo_clr || !run_en || seq_mode) begin
      stage_reg <= '0;
      stage_mask_reg <= '0;
      grp_ready_reg <= 1'b0;
      end_pend_reg <= 1'b0;
    end else if (asm_pop) begin
      stage_reg[head_ch] <= head_data;
      stage_mask_reg <= stage_mask_reg | one_hot(head_ch);
      grp_ready_reg <= head_grp_end | head_burst_end;
      end_pend_reg <= head_burst_end && burst_mode;
    end else if (xfer) begin
      stage_mask_reg <= '0;
      grp_ready_reg <= 1'b0;
      end_pend_reg <= 1'b0;
    end
  end

  // DAC update
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dac_reg <= '0;
      load_reg <= '0;
    end else begin
      load_reg <= '0;
      if (xfer) begin
        for (int i = 0; i < DOS_NUM_CH; i++) begin
          if (stage_mask_reg[i]) dac_reg[i] <= stage_reg[i];
        end
        load_reg <= stage_mask_reg;
      end else if (seq_pop) begin
        dac_reg[head_ch] <= head_data;
        load_reg <= one_hot(head_ch);
      end
    end
  end

  // One shared request: threshold reached or a burst finished
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ctrl_reg[DOS_CTRL_IRQ_EN] &&
                 (thr_flag_reg || burst_stop);
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign avm_address_o = dma_addr_reg;
  assign avm_read_o = dma_rd_reg;
  assign dac_code_o = dac_reg;
  assign dac_load_o = load_reg;
  assign aux_control_line_o = aux_reg;
  assign irq_o = irq_reg;

  a_thr_flag: assert property (@(posedge core_clk_i)
    disable iff (rst_i) thr_flag_reg == (cnt_reg <= {1'b0, thr_reg}))
    else $error("threshold flag disagrees with fill level");
  a_group_xfer: assert property (@(posedge core_clk_i)
    disable iff (rst_i) (!seq_mode && load_reg != '0) |->
    $past(grp_ready_reg) && $past(tick) && !grp_ready_reg)
    else $error("group moved to DACs without a clock");
  a_burst_start: assert property (@(posedge core_clk_i)
    disable iff (rst_i) $rose(burst_reg == DOS_BS_RUN) |-> $past(sync_evt))
    else $error("burst started without sync");
  a_burst_tick: assert property (@(posedge core_clk_i)
    disable iff (rst_i) (burst_mode && load_reg != '0) |->
    $past(rate_pulse_reg))
    else $error("burst update not on rate pulse");
  a_burst_end: assert property (@(posedge core_clk_i)
    disable iff (rst_i) (burst_reg == DOS_BS_RUN && burst_stop) |=>
    burst_reg == DOS_BS_IDLE ##1 load_reg == '0)
    else $error("burst did not end at burst-end word");
  a_seq_direct: assert property (@(posedge core_clk_i)
    disable iff (rst_i) seq_pop |=> load_reg == one_hot($past(head_ch)) &&
    dac_code_o[$past(head_ch)] == $past(head_data))
    else $error("sequential value not written to its DAC");
  a_seq_no_group: assert property (@(posedge core_clk_i)
    disable iff (rst_i) (seq_mode && $past(seq_mode)) |-> !grp_ready_reg)
    else $error("group marker honoured in sequential mode");
  a_part_write: assert property (@(posedge core_clk_i)
    disable iff (rst_i) (avs_write_i && !wait_reg && !bus_full_be) |=>
    $stable(aux_reg) && $stable(ctrl_reg))
    else $error("partial write changed a register");
  a_aux_write: assert property (@(posedge core_clk_i)
    disable iff (rst_i) (bus_wr && avs_address_i == DOS_REG_AUX) |=>
    aux_control_line_o == $past(avs_writedata_i[DOS_AUX_W-1:0]))
    else $error("auxiliary lines not updated");
  a_dma_push: assert property (@(posedge core_clk_i)
    disable iff (rst_i) (dma_push && !pop && !fifo_clr) |=>
    cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("DMA word not stored");
  a_last_grp: assert property (@(posedge core_clk_i)
    disable iff (rst_i) (asm_pop && head_burst_end) |=> grp_ready_reg)
    else $error("burst-end word did not close its group");
endmodule
`default_nettype wire

/* File: test/dos_dma_mem_model.sv */
// DMA memory model: answers the sequencer's reads with random stalls
`timescale 1ns/1ns
`default_nettype none
module dos_dma_mem_model #(
  parameter int STALL_PCT = 50 // Chance of a wait cycle per edge
) (
  input wire logic clk_i, // Core clock
  input wire logic [31:0] address_i, // Byte address
  input wire logic read_i, // Read request
  output logic waitrequest_o, // Wait request
  output logic [31:0] readdata_o // Read data
);
  logic [31:0] mem [0:63];
  initial begin
    waitrequest_o = 1'b1;
    readdata_o = 32'h0;
  end
  // Data is valid while wait is low; outside a read the bus keeps toggling
  always @(posedge clk_i) begin
    if (read_i) begin
      waitrequest_o <= ($urandom % 100) < STALL_PCT;
      readdata_o <= mem[address_i[7:2]];
    end else begin
      waitrequest_o <= 1'b1;
      readdata_o <= ~readdata_o;
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Testbench: registers, DMA feed and DAC sequencing against a queue model
`timescale 1ns/1ns
`default_nettype none
`define CHK(g,e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import dos_pkg::*;
  logic clk = 0, rst = 1, rd = 0, we = 0, ext = 0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h0, rdd, q, maddr, mdata;
  logic wt, mrd, mwt, irq;
  logic [DOS_NUM_CH-1:0][DOS_DATA_W-1:0] code;
  logic [7:0] load;
  logic [3:0] aux, be = 4'hf;
  int err_total = 0, num_checks = 0, cyc = 0, seq = 0, armed = 0;
  logic [20:0] mq[$];
  always #5 clk = ~clk;
  dos_sequencer #(.DEPTH(64), .MAX_DIV_A(400), .MAX_DIV_B(4))
    dos_sequencer_inst (
    .core_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(we), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdd), .avs_waitrequest_o(wt), .avm_address_o(maddr),
    .avm_read_o(mrd), .avm_waitrequest_i(mwt), .avm_readdata_i(mdata),
    .external_sync_input_i(ext), .dac_code_o(code), .dac_load_o(load),
    .aux_control_line_o(aux), .irq_o(irq));
  dos_dma_mem_model dos_dma_mem_model_inst (.clk_i(clk), .address_i(maddr),
    .read_i(mrd), .waitrequest_o(mwt), .readdata_o(mdata));
  // Each load is matched with the words the model expects at the DACs
  always @(posedge clk) begin : mon
    logic [7:0] m;
    logic [20:0] w;
    if (!rst && |load) begin
      if (!armed || mq.size() == 0) begin
        `CHK(load, 8'h00)
      end else begin
        m = 8'h00;
        do begin
          w = mq.pop_front();
          m[w[18:16]] = 1'b1;
          `CHK(code[w[18:16]], w[15:0])
        end while (!seq && !w[19] && !w[20] && mq.size() > 0);
        `CHK(load, m)
      end
    end
  end
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    we <= w;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdd;
    rd <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic push(input logic [20:0] w);
    bus(1, DOS_REG_FIFO, {11'h0, w});
    mq.push_back(w);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    int i;
    logic [20:0] w;
    void'($urandom(32'ha7d46fb6));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(0, DOS_REG_STATUS, 0);
    `CHK(q, 32'h0003_0000)
    bus(0, 6'h3c, 0);
    `CHK(q, 32'h0)
    w = 21'($urandom);
    bus(1, DOS_REG_AUX, {28'h0, w[3:0]});
    bus(0, DOS_REG_AUX, 0);
    `CHK(q[3:0], w[3:0])
    `CHK(aux, w[3:0])
    // Partial byte enables: write ignored, read returns zero
    be <= 4'h3;
    bus(1, DOS_REG_AUX, {28'h0, ~w[3:0]});
    bus(0, DOS_REG_AUX, 0);
    be <= 4'hf;
    `CHK(q, 32'h0)
    `CHK(aux, w[3:0])
    // Sequential updates from the rate, software and trigger sources
    seq = 1;
    armed = 1;
    bus(1, DOS_REG_RATE_A, 32'd334);
    for (int s = 0; s < 3; s++) begin
      for (i = 0; i < 3; i++) push(21'($urandom) & 21'h0fffff);
      bus(1, DOS_REG_CTRL, 32'h22 | (s << 2));
      for (i = 0; i < 3; i++) begin
        if (s == 1) bus(1, DOS_REG_CMD, 32'h1);
        if (s == 2) begin
          ext <= 1'b1;
          idle(5);
          ext <= 1'b0;
        end
        idle(400);
      end
      bus(1, DOS_REG_CTRL, 32'h0);
      `CHK(mq.size(), 0)
    end
    // DMA fills two groups; threshold flag follows the fill level
    seq = 0;
    for (i = 0; i < 8; i++) begin
      w = {1'b0, i == 2 || i == 7, 3'(i), 16'($urandom)};
      dos_dma_mem_model_inst.mem[i] = {11'h0, w};
      mq.push_back(w);
    end
    bus(1, DOS_REG_DMA_ADDR, 32'h0);
    bus(1, DOS_REG_DMA_LEN, 32'd8);
    bus(1, DOS_REG_CMD, 32'h8);
    idle(200);
    bus(0, DOS_REG_STATUS, 0);
    `CHK(q[20:0], 21'h8)
    `CHK(maddr, 32'h20)
    bus(1, DOS_REG_THRESH, 32'd8);
    bus(0, DOS_REG_STATUS, 0);
    `CHK(q[16], 1'b1)
    bus(1, DOS_REG_THRESH, 32'd7);
    bus(0, DOS_REG_STATUS, 0);
    `CHK(q[16], 1'b0)
    bus(1, DOS_REG_CTRL, 32'h24);
    repeat (2) begin
      idle(50);
      bus(1, DOS_REG_CMD, 32'h1);
      idle(50);
    end
    `CHK(mq.size(), 0)
    // Burst waits for sync, then stops at the burst-end word
    bus(1, DOS_REG_CTRL, 32'h0);
    armed = 0;
    push({2'b01, 3'd4, 16'($urandom)});
    push({2'b00, 3'd5, 16'($urandom)});
    push({2'b10, 3'd6, 16'($urandom)});
    bus(1, DOS_REG_CTRL, 32'h21);
    idle(800);
    armed = 1;
    bus(1, DOS_REG_CMD, 32'h2);
    idle(1000);
    `CHK(mq.size(), 0)
    armed = 0;
    push({2'b01, 3'd7, 16'($urandom)});
    idle(800);
    bus(0, DOS_REG_STATUS, 0);
    `CHK(q[19], 1'b0)
    // Empty FIFO is under the threshold, so an enabled request rises
    bus(1, DOS_REG_CTRL, 32'h61);
    idle(2);
    `CHK(irq, 1'b1)
    bus(1, DOS_REG_CTRL, 32'h0);
    idle(2);
    `CHK(irq, 1'b0)
    // Sequential burst from cascaded generators, then a FIFO clear
    mq.delete();
    seq = 1;
    bus(1, DOS_REG_RATE_B, 32'd2);
    for (i = 1; i < 4; i++) push({i == 3, i == 2, 3'(i), 16'($urandom)});
    bus(1, DOS_REG_FIFO, 32'h0001_0000);
    bus(1, DOS_REG_CTRL, 32'h33);
    armed = 1;
    bus(1, DOS_REG_CMD, 32'h2);
    idle(2200);
    `CHK(mq.size(), 0)
    bus(0, DOS_REG_STATUS, 0);
    `CHK(q[19:0], 20'h1_0001)
    bus(1, DOS_REG_CMD, 32'h4);
    bus(0, DOS_REG_STATUS, 0);
    `CHK(q[19:0], 20'h3_0000)
    conclude();
  end
endmodule
`default_nettype wire
